/* sar_ctrl.sv */
// control, successive approximation sequencer and result formatting
// assumes a comparator that answers one cycle after each trial code
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps

// Function
// - every conversion yields ten bits by successive approximation trials
// - eleven single-ended channels and twenty differential pairs (codes 11 to 30) are selectable
// - differential pairs apply gain of one, eight, twenty or thirty-two
// - three-bit reference field picks 1.1V, 2.56V, supply or external
// - entering idle or noise-reduction sleep starts a conversion once core halts
// - completion raises its request even if another interrupt woke the core
// - other sleep modes leave the converter enabled
// - completion sets the done flag and loads both result bytes
// - single-ended result spans 0x000 to 0x3ff
// - unipolar differential clamps negative difference to zero
// - polarity mode resets unipolar, bipolar when control b bit set
// - bipolar result is two's complement 0x201 to 0x1ff
// - bipolar result top bit is the sign, one meaning negative
module sar_ctrl (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic [1:0] sleep_mode,
   input  wire logic       core_halted,
   input  wire logic       cmp_above,
   input  wire logic       cmp_negative,
   output logic      [4:0] mux_channel,
   output logic            mux_differential,
   output logic      [1:0] gain_select,
   output logic      [2:0] reference_select,
   output logic            reference_decouple_pin,
   output logic            analog_enable,
   output logic            sample_hold,
   output logic      [9:0] trial_code,
   output logic            irq
);
   // ************************************************************
   // registers
   // ************************************************************
   logic [7:0] channel_select_register_q;
   logic       converter_enable_bit_q;
   logic       free_run_q;
   logic       irq_enable_q;
   logic       bipolar_mode_bit_q;
   logic [1:0] gain_q;
   logic [7:0] result_low_byte_q;
   logic [1:0] result_high_byte_q;
   logic [1:0] status_q;
   logic [1:0] mask_q;
   logic       start_req_q;
   logic       sleep_armed_q;

   typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_TRIAL, S_DONE} state_t;
   localparam logic [9:0] TRIAL_MSB = 10'(1 << (sar_pkg::RESULT_W - 1));
   state_t     state_q;
   logic [3:0] bit_idx_q;
   logic [3:0] settle_cnt_q;
   logic [9:0] sar_q;
   logic       neg_q;
   logic [9:0] formatted;
   logic       finish;
   logic       single_ended;
   logic       wr_hit_ctla;

   // the temperature sensor sits on a single-ended input
   assign single_ended = (channel_select_register_q[sar_pkg::CH_FIELD_LSB +: 4] <
                          4'(sar_pkg::NUM_SINGLE) &&
                          !channel_select_register_q[sar_pkg::CH_FIELD_LSB + 4]) ||
                         channel_select_register_q[4:0] == sar_pkg::CH_SENSOR;
   assign finish = (state_q == S_DONE);
   assign wr_hit_ctla = reg_wr && reg_addr == sar_pkg::ADDR_CONTROL_A;

   // ************************************************************
   // control registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         channel_select_register_q <= sar_pkg::RESET_BYTE;
         converter_enable_bit_q    <= 1'b0;
         free_run_q                <= 1'b0;
         irq_enable_q              <= 1'b0;
         bipolar_mode_bit_q        <= 1'b0;
         gain_q                    <= 2'(sar_pkg::GAIN_1X);
         mask_q                    <= 2'h0;
      end else if (clk_en && reg_wr) begin
         unique case (reg_addr)
            sar_pkg::ADDR_CHANNEL_SELECT: channel_select_register_q <= reg_wdata;
            sar_pkg::ADDR_CONTROL_A: begin
               converter_enable_bit_q <= reg_wdata[sar_pkg::CTLA_ENABLE];
               free_run_q             <= reg_wdata[sar_pkg::CTLA_FREE_RUN];
               irq_enable_q           <= reg_wdata[sar_pkg::CTLA_IRQ_EN];
            end
            sar_pkg::ADDR_CONTROL_B: begin
               bipolar_mode_bit_q <= reg_wdata[sar_pkg::CTLB_BIPOLAR];
               gain_q <= reg_wdata[sar_pkg::CTLB_GAIN_LSB +: sar_pkg::CTLB_GAIN_W];
            end
            sar_pkg::ADDR_IRQ_MASK: mask_q <= reg_wdata[1:0];
            default: ;
         endcase
      end
   end

   // ************************************************************
   // start requests
   // ************************************************************
   // sleep start arms once per sleep entry so a long sleep does not rerun
   always_ff @(posedge clk) begin
      if (rst) begin
         start_req_q   <= 1'b0;
         sleep_armed_q <= 1'b0;
      end else if (clk_en) begin
         if (!core_halted)
            sleep_armed_q <= 1'b0;
         if (wr_hit_ctla && reg_wdata[sar_pkg::CTLA_START] &&
             reg_wdata[sar_pkg::CTLA_ENABLE])
            start_req_q <= 1'b1;
         else if (core_halted && !sleep_armed_q && converter_enable_bit_q &&
                  state_q == S_IDLE && !free_run_q && irq_enable_q &&
                  (sleep_mode == 2'(sar_pkg::SLEEP_IDLE) ||
                   sleep_mode == 2'(sar_pkg::SLEEP_NOISE_REDUCTION))) begin
            start_req_q   <= 1'b1;
            sleep_armed_q <= 1'b1;
         end else if (finish && free_run_q && converter_enable_bit_q)
            start_req_q <= 1'b1;
         else if (state_q == S_SETTLE)
            start_req_q <= 1'b0;
      end
   end

   // ************************************************************
   // successive approximation sequencer
   // ************************************************************
   // enable only drops by software; sleep mode never clears it
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q      <= S_IDLE;
         bit_idx_q    <= 4'h0;
         settle_cnt_q <= 4'h0;
         sar_q        <= 10'h000;
         neg_q        <= 1'b0;
         trial_code   <= 10'h000;
      end else if (clk_en) begin
         unique case (state_q)
            S_IDLE: if (start_req_q && converter_enable_bit_q) begin
               state_q      <= S_SETTLE;
               settle_cnt_q <= 4'(sar_pkg::SETTLE_CYC);
               sar_q        <= 10'h000;
            end
            S_SETTLE: if (settle_cnt_q == 4'h1) begin
               // first code leaves with the state change, so the comparator
               // answer for the msb is settled at the next edge
               state_q    <= S_TRIAL;
               bit_idx_q  <= 4'(sar_pkg::RESULT_W - 1);
               neg_q      <= cmp_negative;
               sar_q      <= TRIAL_MSB;
               trial_code <= TRIAL_MSB;
            end else begin
               settle_cnt_q <= settle_cnt_q - 4'h1;
            end
            S_TRIAL: begin
               // keep the trial bit only when the input is at or above the code
               if (!cmp_above) begin
                  sar_q[bit_idx_q]      <= 1'b0;
                  trial_code[bit_idx_q] <= 1'b0;
               end
               if (bit_idx_q == 4'h0) begin
                  state_q    <= S_DONE;
                  trial_code <= 10'h000;
               end else begin
                  bit_idx_q                    <= bit_idx_q - 4'h1;
                  sar_q[bit_idx_q - 4'h1]      <= 1'b1;
                  trial_code[bit_idx_q - 4'h1] <= 1'b1;
               end
            end
            S_DONE: state_q <= S_IDLE;
         endcase
         if (!converter_enable_bit_q) begin
            state_q    <= S_IDLE;
            trial_code <= 10'h000;
         end
      end
   end

   // magnitude from the sar, sign from the comparator polarity sense
   always_comb begin
      if (single_ended)
         formatted = sar_q;
      else if (!bipolar_mode_bit_q)
         formatted = neg_q ? 10'h000 : sar_q;
      else if (neg_q)
         formatted = 10'(~{1'b0, sar_q[9:1]} + 10'h001);
      else
         formatted = {1'b0, sar_q[9:1]};
   end

   // ************************************************************
   // results and interrupt status
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         result_low_byte_q  <= sar_pkg::RESET_BYTE;
         result_high_byte_q <= 2'h0;
      end else if (clk_en && finish) begin
         result_low_byte_q  <= formatted[7:0];
         result_high_byte_q <= formatted[9:8];
      end
   end

   // set wins over a same-cycle write-one clear
   always_ff @(posedge clk) begin
      if (rst)
         status_q <= 2'h0;
      else if (clk_en) begin
         for (int i = 0; i < 2; i++) begin
            if (reg_wr && reg_addr == sar_pkg::ADDR_IRQ_STATUS && reg_wdata[i])
               status_q[i] <= 1'b0;
         end
         if (finish) begin
            status_q[sar_pkg::STS_DONE] <= 1'b1;
            if (status_q[sar_pkg::STS_DONE])
               status_q[sar_pkg::STS_OVERRUN] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst)
         irq <= 1'b0;
      else if (clk_en)
         irq <= |(status_q & mask_q) &&
                (irq_enable_q || !status_q[sar_pkg::STS_DONE] ||
                 mask_q[sar_pkg::STS_OVERRUN]);
   end

   // ************************************************************
   // register read port
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst)
         reg_rdata <= sar_pkg::RESET_BYTE;
      else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            unique case (reg_addr)
               sar_pkg::ADDR_CHANNEL_SELECT: reg_rdata <= channel_select_register_q;
               sar_pkg::ADDR_CONTROL_A: reg_rdata <= {converter_enable_bit_q, 1'b0,
                  free_run_q, state_q != S_IDLE, irq_enable_q, 3'h0};
               sar_pkg::ADDR_CONTROL_B: reg_rdata <= {bipolar_mode_bit_q, 5'h00, gain_q};
               sar_pkg::ADDR_RESULT_LOW: reg_rdata <= result_low_byte_q;
               sar_pkg::ADDR_RESULT_HIGH: reg_rdata <= {6'h00, result_high_byte_q};
               sar_pkg::ADDR_IRQ_STATUS: reg_rdata <= {6'h00, status_q};
               sar_pkg::ADDR_IRQ_MASK: reg_rdata <= {6'h00, mask_q};
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ************************************************************
   // analog front end drive
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         mux_channel            <= 5'h00;
         mux_differential       <= 1'b0;
         gain_select            <= 2'h0;
         reference_select       <= 3'h0;
         reference_decouple_pin <= 1'b0;
         analog_enable          <= 1'b0;
         sample_hold            <= 1'b0;
      end else if (clk_en) begin
         mux_channel      <= channel_select_register_q[sar_pkg::CH_FIELD_LSB +:
                             sar_pkg::CH_FIELD_W];
         mux_differential <= !single_ended &&
                             channel_select_register_q[4:0] != sar_pkg::CH_SENSOR;
         gain_select      <= single_ended ? 2'(sar_pkg::GAIN_1X) : gain_q;
         // supply reference is not offered to differential pairs
         reference_select <= (!single_ended &&
            channel_select_register_q[sar_pkg::REF_FIELD_LSB +: sar_pkg::REF_FIELD_W] ==
            3'(sar_pkg::REF_VCC)) ? 3'(sar_pkg::REF_INT_2V56) :
            channel_select_register_q[sar_pkg::REF_FIELD_LSB +: sar_pkg::REF_FIELD_W];
         reference_decouple_pin <= channel_select_register_q[sar_pkg::REF_FIELD_LSB +:
            sar_pkg::REF_FIELD_W] == 3'(sar_pkg::REF_INT_2V56_DECOUPLED);
         analog_enable    <= converter_enable_bit_q;
         sample_hold      <= state_q == S_TRIAL;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   a_done_sets_flag: assert property (@(posedge clk) disable iff (rst)
      (clk_en && finish) |=> status_q[sar_pkg::STS_DONE])
      else $error("done flag not set after completion");
   a_result_holds: assert property (@(posedge clk) disable iff (rst)
      !finish |=> $stable(result_low_byte_q) && $stable(result_high_byte_q))
      else $error("result changed without completion");
   a_unipolar_clamp: assert property (@(posedge clk) disable iff (rst)
      (clk_en && finish && !single_ended && !bipolar_mode_bit_q && neg_q)
      |=> result_low_byte_q == 8'h00 && result_high_byte_q == 2'h0)
      else $error("negative unipolar not clamped");
   a_bipolar_sign: assert property (@(posedge clk) disable iff (rst)
      (clk_en && finish && !single_ended && bipolar_mode_bit_q && sar_q[9:1] != 9'h000)
      |=> result_high_byte_q[1] == $past(neg_q))
      else $error("bipolar sign bit wrong");
   a_polarity_reset: assert property (@(posedge clk)
      rst |=> !bipolar_mode_bit_q)
      else $error("polarity mode not unipolar after reset");
   a_sleep_start: assert property (@(posedge clk) disable iff (rst)
      (clk_en && state_q == S_IDLE && start_req_q && converter_enable_bit_q)
      |=> state_q == S_SETTLE)
      else $error("conversion did not start");
   a_trial_length: assert property (@(posedge clk)
      disable iff (rst || !clk_en || !converter_enable_bit_q)
      $rose(state_q == S_TRIAL) |=> (state_q == S_TRIAL) [*8] ##1 state_q == S_TRIAL
      ##1 state_q == S_DONE)
      else $error("trial phase length wrong");
   a_enable_kept: assert property (@(posedge clk) disable iff (rst)
      (!reg_wr && core_halted) |=> converter_enable_bit_q == $past(converter_enable_bit_q))
      else $error("sleep changed the enable");
   a_sleep_entry: assert property (@(posedge clk) disable iff (rst || !clk_en)
      (core_halted && !sleep_armed_q && converter_enable_bit_q && state_q == S_IDLE &&
       !free_run_q && irq_enable_q && !reg_wr && (sleep_mode == 2'(sar_pkg::SLEEP_IDLE) ||
       sleep_mode == 2'(sar_pkg::SLEEP_NOISE_REDUCTION))) |=> ##1 state_q == S_SETTLE)
      else $error("sleep entry did not start a conversion");
   a_first_code: assert property (@(posedge clk) disable iff (rst)
      $rose(state_q == S_TRIAL) |-> trial_code == TRIAL_MSB)
      else $error("first trial code is not the msb");
   a_irq_quiet: assert property (@(posedge clk) disable iff (rst)
      (clk_en && !(|(status_q & mask_q))) |=> !irq)
      else $error("irq high with no unmasked status");
   a_read_idle: assert property (@(posedge clk) disable iff (rst)
      (clk_en && !reg_rd) |=> reg_rdata == 8'h00)
      else $error("read data not zero without a read");
   a_overrun_set: assert property (@(posedge clk) disable iff (rst)
      (clk_en && finish && status_q[sar_pkg::STS_DONE]) |=> status_q[sar_pkg::STS_OVERRUN])
      else $error("overrun not flagged");
endmodule

/* sar_pkg.sv */
// package for the converter control and result formatting block
// assumes one 200 MHz system clock and a plain strobe register port
package sar_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [2:0] ADDR_CHANNEL_SELECT = 3'h0;
   localparam logic [2:0] ADDR_CONTROL_A      = 3'h1;
   localparam logic [2:0] ADDR_CONTROL_B      = 3'h2;
   localparam logic [2:0] ADDR_RESULT_LOW     = 3'h3;
   localparam logic [2:0] ADDR_RESULT_HIGH    = 3'h4;
   localparam logic [2:0] ADDR_IRQ_STATUS     = 3'h5;
   localparam logic [2:0] ADDR_IRQ_MASK       = 3'h6;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int CH_FIELD_LSB   = 0;
   localparam int CH_FIELD_W     = 5;
   localparam int REF_FIELD_LSB  = 5;
   localparam int REF_FIELD_W    = 3;
   localparam int CTLA_ENABLE    = 7;
   localparam int CTLA_START     = 6;
   localparam int CTLA_FREE_RUN  = 5;
   localparam int CTLA_IRQ_EN    = 3;
   localparam int CTLB_BIPOLAR   = 7;
   localparam int CTLB_GAIN_LSB  = 0;
   localparam int CTLB_GAIN_W    = 2;
   localparam int STS_DONE       = 0;
   localparam int STS_OVERRUN    = 1;
   localparam int CTLA_BUSY      = 4;

   // ************************************************************
   // sizes and codes
   // ************************************************************
   localparam int RESULT_W       = 10;
   localparam int NUM_SINGLE     = 11;
   localparam int NUM_DIFF       = 16;
   localparam logic [4:0] CH_SENSOR = 5'h1f;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [9:0] RESULT_MAX = 10'h3ff;
   localparam logic [9:0] BIP_MIN    = 10'h200;
   localparam logic [9:0] BIP_MAX    = 10'h1ff;

   typedef enum logic [1:0] {GAIN_1X, GAIN_8X, GAIN_20X, GAIN_32X} gain_t;
   typedef enum logic [2:0] {
      REF_VCC      = 3'h0,
      REF_EXTERNAL = 3'h1,
      REF_INT_1V1  = 3'h2,
      REF_INT_2V56 = 3'h6,
      REF_INT_2V56_DECOUPLED = 3'h7
   } ref_t;
   typedef enum logic [1:0] {
      SLEEP_NONE, SLEEP_IDLE, SLEEP_NOISE_REDUCTION, SLEEP_OTHER
   } sleep_t;

   // settle time before the bit trials, in ns
   localparam int SETTLE_NS     = 20;
   localparam int CLK_PERIOD_NS = 5;
   localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* sar_analog_model.sv */
// far-side model: sample-and-hold, polarity sense and comparator of the converter
// assumes trial_code is registered and its answer is read at the following edge
`timescale 1ns/1ps
module sar_analog_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       analog_enable,
   input  wire logic       sample_hold,
   input  wire logic [9:0] trial_code,
   input  wire logic [9:0] level,
   input  wire logic       negative,
   output logic            cmp_above,
   output logic            cmp_negative
);
   // ************************************************************
   // comparator
   // ************************************************************
   // level is the scaled input magnitude, negative the sign of a difference
   logic [9:0] held_q;

   // the hold switch freezes the input while the bit trials run
   always_ff @(posedge clk) begin
      if (rst)
         held_q <= 10'h000;
      else if (!sample_hold)
         held_q <= level;
   end

   // the comparator is continuous; the hold and the polarity sense are clocked
   always_comb cmp_above = analog_enable && (held_q >= trial_code);

   always_ff @(posedge clk) begin
      if (rst)
         cmp_negative <= 1'b0;
      else if (analog_enable)
         cmp_negative <= negative;
      else
         // powered down: the sense is meaningless, so it toggles rather than holds
         cmp_negative <= ~cmp_negative;
   end
endmodule

/* tb.sv */
// testbench for the converter control block: registers, formats, irq, sleep starts
// assumes sar_analog_model on the far side and a 200 MHz system clock
`timescale 1ns/1ps
module tb;
   // ************************************************************
   // signals
   // ************************************************************
   logic       clk, rst, clk_en, reg_wr, reg_rd, core_halted, negative;
   logic       cmp_above, cmp_negative, mux_differential, reference_decouple_pin;
   logic       analog_enable, sample_hold, irq;
   logic [2:0] reg_addr, reference_select;
   logic [7:0] reg_wdata, reg_rdata, b;
   logic [1:0] sleep_mode, gain_select;
   logic [4:0] mux_channel;
   logic [9:0] trial_code, level, res, e;
   int         error_cnt, comparisons;
   logic [2:0] refs [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};

   sar_ctrl dut (.clk(clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sleep_mode(sleep_mode), .core_halted(core_halted), .cmp_above(cmp_above),
      .cmp_negative(cmp_negative), .mux_channel(mux_channel),
      .mux_differential(mux_differential), .gain_select(gain_select),
      .reference_select(reference_select), .reference_decouple_pin(reference_decouple_pin),
      .analog_enable(analog_enable), .sample_hold(sample_hold), .trial_code(trial_code),
      .irq(irq));
   sar_analog_model model (.clk(clk), .rst(rst), .analog_enable(analog_enable),
      .sample_hold(sample_hold), .trial_code(trial_code), .level(level),
      .negative(negative), .cmp_above(cmp_above), .cmp_negative(cmp_negative));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ************************************************************
   // bus and check tasks
   // ************************************************************
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   // waits for completion, checks flag and request, returns result, clears the flag
   task automatic finish(output logic [9:0] r);
      logic [7:0] lo, hi, s;
      for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk);
      check("irq on done", 10'h1, {9'h0, irq});
      rd(sar_pkg::ADDR_IRQ_STATUS, s);
      check("done flag", 10'h1, {9'h0, s[sar_pkg::STS_DONE]});
      rd(sar_pkg::ADDR_RESULT_LOW, lo);
      rd(sar_pkg::ADDR_RESULT_HIGH, hi);
      r = {hi[1:0], lo};
      wr(sar_pkg::ADDR_IRQ_STATUS, 8'h01);
      settle();
      check("irq after clear", 10'h0, {9'h0, irq});
   endtask
   task automatic conv(input logic [9:0] lvl, input logic neg, output logic [9:0] r);
      level    <= lvl;
      negative <= neg;
      wr(sar_pkg::ADDR_CONTROL_A, 8'hc8);
      finish(r);
   endtask
   task automatic final_report();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ************************************************************
   // watchdog: whole run needs about a thousand cycles
   // ************************************************************
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      final_report();
   end

   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      clk_en = 1'b1;
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      sleep_mode = 2'h0;
      core_halted = 1'b0;
      level = 10'h000;
      negative = 1'b0;
      error_cnt = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         rd(a[2:0], b);
         check("reset value", 10'h0, {2'h0, b});
      end
      for (int c = 0; c < 32; c++) begin
         wr(sar_pkg::ADDR_CHANNEL_SELECT, {3'h6, c[4:0]});
         settle();
         check("channel", c[9:0], {5'h0, mux_channel});
         check("differential", (c < 11 || c == 31) ? 10'h0 : 10'h1,
            {9'h0, mux_differential});
      end
      wr(sar_pkg::ADDR_CHANNEL_SELECT, 8'h0b);
      for (int g = 0; g < 4; g++) begin
         wr(sar_pkg::ADDR_CONTROL_B, g[7:0]);
         settle();
         check("gain", g[9:0], {8'h0, gain_select});
      end
      settle();
      check("diff vcc ref", 10'h6, {7'h0, reference_select});
      for (int i = 0; i < 5; i++) begin
         wr(sar_pkg::ADDR_CHANNEL_SELECT, {refs[i], 5'h03});
         rd(sar_pkg::ADDR_CHANNEL_SELECT, b);
         check("select readback", {2'h0, refs[i], 5'h03}, {2'h0, b});
         check("reference", {7'h0, refs[i]}, {7'h0, reference_select});
         check("decouple", {9'h0, refs[i] == 3'h7}, {9'h0, reference_decouple_pin});
      end
      // single-ended on the sensor channel with the 1.1V reference, single mode
      wr(sar_pkg::ADDR_CHANNEL_SELECT, {3'h2, sar_pkg::CH_SENSOR});
      wr(sar_pkg::ADDR_CONTROL_B, 8'h00);
      wr(sar_pkg::ADDR_IRQ_MASK, 8'h01);
      foreach (refs[i]) begin
         e = 10'h3ff - 10'(i * 341);
         conv(e, 1'b0, res);
         check("single ended", e, res);
      end
      conv(10'h000, 1'b0, res);
      check("single zero", 10'h000, res);
      level <= 10'h2aa;
      repeat (40) @(posedge clk);
      rd(sar_pkg::ADDR_RESULT_LOW, b);
      check("result hold", 10'h000, {2'h0, b});
      wr(sar_pkg::ADDR_CHANNEL_SELECT, 8'hcb);
      wr(sar_pkg::ADDR_CONTROL_B, 8'h01);
      conv(10'h234, 1'b0, res);
      check("unipolar pos", 10'h234, res);
      conv(10'h234, 1'b1, res);
      check("unipolar clamp", 10'h000, res);
      wr(sar_pkg::ADDR_CONTROL_B, 8'h81);
      for (int i = 0; i < 4; i++) begin
         e = (i < 2) ? 10'h3ff : 10'h100;
         conv(e, i[0], res);
         e = {1'b0, e[9:1]};
         if (i[0])
            e = 10'h000 - e;
         check("bipolar", e, res);
         check("sign bit", {9'h0, i[0]}, {9'h0, res[9]});
      end
      // masked completion keeps irq low until the mask opens
      wr(sar_pkg::ADDR_CONTROL_B, 8'h00);
      wr(sar_pkg::ADDR_IRQ_MASK, 8'h00);
      wr(sar_pkg::ADDR_CONTROL_A, 8'hc8);
      repeat (60) @(posedge clk);
      #1 check("masked irq", 10'h0, {9'h0, irq});
      wr(sar_pkg::ADDR_IRQ_MASK, 8'h01);
      finish(res);
      // free running back to back conversions flag an overrun
      wr(sar_pkg::ADDR_CONTROL_A, 8'he8);
      repeat (60) @(posedge clk);
      wr(sar_pkg::ADDR_CONTROL_A, 8'h88);
      repeat (30) @(posedge clk);
      rd(sar_pkg::ADDR_IRQ_STATUS, b);
      check("overrun", 10'h3, {2'h0, b});
      wr(sar_pkg::ADDR_IRQ_STATUS, 8'h03);
      // sleep starts: enabled, idle, single mode, irq enabled beforehand
      wr(sar_pkg::ADDR_CHANNEL_SELECT, 8'h43);
      wr(sar_pkg::ADDR_CONTROL_A, 8'h88);
      for (int m = 1; m < 3; m++) begin
         level <= 10'h1c3 + 10'(m);
         @(posedge clk);
         sleep_mode  <= m[1:0];
         core_halted <= 1'b1;
         if (m == 1) begin
            // another source wakes the core early
            repeat (4) @(posedge clk);
            core_halted <= 1'b0;
         end
         finish(res);
         check("sleep result", 10'h1c3 + 10'(m), res);
         core_halted <= 1'b0;
         sleep_mode  <= 2'h0;
      end
      @(posedge clk);
      sleep_mode  <= 2'h3;
      core_halted <= 1'b1;
      repeat (60) @(posedge clk);
      #1 check("other sleep enable", 10'h1, {9'h0, analog_enable});
      check("other sleep no start", 10'h0, {9'h0, irq});
      // a frozen block must ignore the bus
      clk_en <= 1'b0;
      wr(sar_pkg::ADDR_CONTROL_B, 8'h80);
      clk_en <= 1'b1;
      rd(sar_pkg::ADDR_CONTROL_B, b);
      check("frozen write", 10'h0, {2'h0, b});
      final_report();
   end
endmodule
